// file: src/swrtc_pkg.sv
`default_nettype none

package swrtc_pkg;

    // Register byte offsets
    localparam logic [11:0] START_WIN_OFFSET = 12'h000;
    localparam logic [11:0] DATA_WIN_OFFSET  = 12'h004;
    localparam logic [11:0] RX_CTRL_OFFSET   = 12'h008;
    localparam logic [11:0] RX_STATUS_OFFSET = 12'h00C;

    // Writable bits and reset values
    localparam logic [31:0] START_WIN_MASK  = 32'h0000_7777;
    localparam logic [31:0] DATA_WIN_MASK   = 32'h0077_7701;
    localparam logic [31:0] START_WIN_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_WIN_RESET  = 32'h0000_0000;

    // Field positions in start_bit_timing_window
    localparam int START_CYCLE_MAX_LSB = 12;
    localparam int START_CYCLE_MIN_LSB = 8;
    localparam int START_RISE_MAX_LSB  = 4;
    localparam int START_RISE_MIN_LSB  = 0;

    // Field positions in data_waveform_timing_window
    localparam int ZERO_RISE_LATEST_LSB   = 20;
    localparam int ZERO_RISE_EARLIEST_LSB = 16;
    localparam int ONE_RISE_LATEST_LSB    = 12;
    localparam int ONE_RISE_EARLIEST_LSB  = 8;
    localparam int WAVE_CHECK_EN_BIT      = 0;

    // Control and status bits
    localparam int RX_ENABLE_BIT   = 0;
    localparam int RX_BUSY_BIT     = 1;
    localparam int STAT_START_BIT  = 0;
    localparam int STAT_WAVE_BIT   = 1;
    localparam int STAT_BUSY_BIT   = 2;

    // Base times in sample periods
    localparam logic [7:0] START_CYCLE_MAX_BASE = 8'h9A;
    localparam logic [7:0] START_CYCLE_MIN_BASE = 8'h8D;
    localparam logic [7:0] START_RISE_MAX_BASE  = 8'h80;
    localparam logic [7:0] START_RISE_MIN_BASE  = 8'h73;
    localparam logic [7:0] ZERO_RISE_LATEST_BASE   = 8'h38;
    localparam logic [7:0] ZERO_RISE_EARLIEST_BASE = 8'h2B;
    localparam logic [7:0] ONE_RISE_LATEST_BASE    = 8'h1A;
    localparam logic [7:0] ONE_RISE_EARLIEST_BASE  = 8'h0D;

    localparam logic [7:0] COUNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START_LOW,
        RX_START_HIGH,
        RX_DATA_LOW,
        RX_DATA_HIGH
    } swrtc_state_type;

endpackage

`default_nettype wire

// file: src/swrtc_bit_timer.sv
`default_nettype none

module swrtc_bit_timer #(
    parameter int CNT_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sampleTick,
    input  wire logic             restart,
    output logic      [CNT_W-1:0] bitCount
);
    import swrtc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } swrtc_timer_type;

    swrtc_timer_type r;
    swrtc_timer_type next_r;

    // Saturating count of fs periods since the bit start
    always_comb begin
        next_r = r;
        if (restart) begin
            next_r.count = CNT_W'(COUNT_RESET);
        end else if (sampleTick && (r.count != {CNT_W{1'b1}})) begin
            next_r.count = r.count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r.count <= CNT_W'(COUNT_RESET);
        end else begin
            r <= next_r;
        end
    end

    assign bitCount = r.count;

endmodule

`default_nettype wire

// file: src/swrtc_top.sv
// Notes on behaviour
// - Longest start cycle is 154 fs periods plus field at bits 14-12.
// - Shortest start cycle is 141 fs periods minus field at bits 10-8.
// - Latest start rising edge is 128 fs periods plus field at bits 6-4.
// - Earliest start rising edge is 115 fs periods minus field at bits 2-0.
// - Start bit needs both rising edge and cycle length inside their windows.
// - Latest proper zero rising edge is 56 plus field at bits 22-20.
// - Earliest proper zero rising edge is 43 minus field at bits 18-16.
// - Waveform check only while its enable bit is one; mismatch flags error.
// - One rising edge accepted from 13 minus field to 26 plus field.
// - Rising edge between one latest and zero earliest is an error.
// - No rising edge before zero latest limit is an error.
//
// The APB interface to the registers and the register offsets were decided locally.
`default_nettype none

module swrtc_top #(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sampleTick,
    input  wire logic              lineIn,
    output logic                   startValid,
    output logic                   waveError
);
    import swrtc_pkg::*;

    typedef struct packed {
        swrtc_state_type state;
        logic            lineLast;
        logic [31:0]     startWin;
        logic [31:0]     dataWin;
        logic            rxEnable;
        logic            stickStart;
        logic            stickWave;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic            startValid;
        logic            waveError;
    } swrtc_regs_type;

    swrtc_regs_type r;
    swrtc_regs_type next_r;

    logic [CNT_W-1:0] bitCount;
    logic             restart;
    logic             rise;
    logic             fall;
    logic             waveEn;
    logic [7:0]       cycMax;
    logic [7:0]       cycMin;
    logic [7:0]       riseMax;
    logic [7:0]       riseMin;
    logic [7:0]       zeroMax;
    logic [7:0]       zeroMin;
    logic [7:0]       oneMax;
    logic [7:0]       oneMin;
    logic [7:0]       cnt;

    function automatic logic [7:0] addAdj(input logic [7:0] base, input logic [31:0] w,
                                          input int lsb);
        addAdj = base + {5'h00, w[lsb +: 3]};
    endfunction

    function automatic logic [7:0] subAdj(input logic [7:0] base, input logic [31:0] w,
                                          input int lsb);
        subAdj = base - {5'h00, w[lsb +: 3]};
    endfunction

    function automatic logic inWin(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
        inWin = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        isAddr = (a == ADDR_W'(off));
    endfunction

    swrtc_bit_timer #(
        .CNT_W      (CNT_W)
    ) u_timer (
        .clk        (clk),
        .rst        (rst),
        .sampleTick (sampleTick),
        .restart    (restart),
        .bitCount   (bitCount)
    );

    // Window limits from the two timing registers
    always_comb begin
        cnt     = 8'(bitCount);
        waveEn  = r.dataWin[WAVE_CHECK_EN_BIT];
        cycMax  = addAdj(START_CYCLE_MAX_BASE, r.startWin, START_CYCLE_MAX_LSB);
        cycMin  = subAdj(START_CYCLE_MIN_BASE, r.startWin, START_CYCLE_MIN_LSB);
        riseMax = addAdj(START_RISE_MAX_BASE, r.startWin, START_RISE_MAX_LSB);
        riseMin = subAdj(START_RISE_MIN_BASE, r.startWin, START_RISE_MIN_LSB);
        zeroMax = addAdj(ZERO_RISE_LATEST_BASE, r.dataWin, ZERO_RISE_LATEST_LSB);
        zeroMin = subAdj(ZERO_RISE_EARLIEST_BASE, r.dataWin, ZERO_RISE_EARLIEST_LSB);
        oneMax  = addAdj(ONE_RISE_LATEST_BASE, r.dataWin, ONE_RISE_LATEST_LSB);
        oneMin  = subAdj(ONE_RISE_EARLIEST_BASE, r.dataWin, ONE_RISE_EARLIEST_LSB);
        rise    = !r.lineLast && lineIn;
        fall    = r.lineLast && !lineIn;
    end

    always_comb begin
        logic        setup;
        logic        access;
        logic        mapped;
        logic        startEvt;
        logic        waveEvt;
        logic        wStat;
        logic [31:0] rd;
        setup    = psel && !penable;
        access   = psel && penable && r.pready;
        mapped   = isAddr(paddr, START_WIN_OFFSET) || isAddr(paddr, DATA_WIN_OFFSET)
                   || isAddr(paddr, RX_CTRL_OFFSET) || isAddr(paddr, RX_STATUS_OFFSET);
        startEvt = 1'b0;
        waveEvt  = 1'b0;
        wStat    = 1'b0;
        restart  = 1'b0;
        rd       = 32'h0000_0000;
        next_r   = r;
        next_r.lineLast = lineIn;

        // Receive sequencing
        case (r.state)
            RX_IDLE: begin
                if (fall) begin
                    next_r.state = RX_START_LOW;
                    restart      = 1'b1;
                end
            end
            RX_START_LOW: begin
                if (rise) begin
                    next_r.state = inWin(cnt, riseMin, riseMax) ? RX_START_HIGH : RX_IDLE;
                end else if (cnt > riseMax) begin
                    next_r.state = RX_IDLE;
                end
            end
            RX_START_HIGH: begin
                if (fall) begin
                    restart = 1'b1;
                    if (inWin(cnt, cycMin, cycMax)) begin
                        startEvt     = 1'b1;
                        next_r.state = RX_DATA_LOW;
                    end else begin
                        next_r.state = RX_START_LOW;
                    end
                end else if (cnt > cycMax) begin
                    next_r.state = RX_IDLE;
                end
            end
            RX_DATA_LOW: begin
                if (rise) begin
                    next_r.state = RX_DATA_HIGH;
                    waveEvt = waveEn && ((cnt < oneMin)
                              || ((cnt > oneMax) && (cnt < zeroMin))
                              || (cnt > zeroMax));
                end else if (cnt > zeroMax) begin
                    waveEvt      = waveEn;
                    next_r.state = RX_IDLE;
                end
            end
            RX_DATA_HIGH: begin
                if (fall) begin
                    next_r.state = RX_DATA_LOW;
                    restart      = 1'b1;
                end else if (cnt > cycMax) begin
                    next_r.state = RX_IDLE;
                end
            end
            default: begin
                next_r.state = RX_IDLE;
            end
        endcase
        if (!r.rxEnable) begin
            next_r.state = RX_IDLE;
            startEvt     = 1'b0;
            waveEvt      = 1'b0;
        end
        next_r.startValid = startEvt;
        next_r.waveError  = waveEvt;

        // APB slave, answers in the first access cycle
        next_r.pready  = setup;
        next_r.pslverr = setup && !mapped;
        if (isAddr(paddr, START_WIN_OFFSET)) begin
            rd = r.startWin;
        end else if (isAddr(paddr, DATA_WIN_OFFSET)) begin
            rd = r.dataWin;
        end else if (isAddr(paddr, RX_CTRL_OFFSET)) begin
            rd[RX_ENABLE_BIT] = r.rxEnable;
            rd[RX_BUSY_BIT]   = (r.state != RX_IDLE);
        end else if (isAddr(paddr, RX_STATUS_OFFSET)) begin
            rd[STAT_START_BIT] = r.stickStart;
            rd[STAT_WAVE_BIT]  = r.stickWave;
            rd[STAT_BUSY_BIT]  = (r.state != RX_IDLE);
        end
        if (setup && !pwrite) begin
            next_r.prdata = rd;
        end
        if (access && pwrite) begin
            if (isAddr(paddr, START_WIN_OFFSET)) begin
                next_r.startWin = pwdata & START_WIN_MASK;
            end else if (isAddr(paddr, DATA_WIN_OFFSET)) begin
                next_r.dataWin = pwdata & DATA_WIN_MASK;
            end else if (isAddr(paddr, RX_CTRL_OFFSET)) begin
                next_r.rxEnable = pwdata[RX_ENABLE_BIT];
            end else if (isAddr(paddr, RX_STATUS_OFFSET)) begin
                wStat = 1'b1;
            end
        end

        // Sticky flags, write one to clear, a new event wins
        next_r.stickStart = (r.stickStart && !(wStat && pwdata[STAT_START_BIT])) || startEvt;
        next_r.stickWave  = (r.stickWave && !(wStat && pwdata[STAT_WAVE_BIT])) || waveEvt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r.state      <= RX_IDLE;
            r.lineLast   <= 1'b1;
            r.startWin   <= START_WIN_RESET;
            r.dataWin    <= DATA_WIN_RESET;
            r.rxEnable   <= 1'b0;
            r.stickStart <= 1'b0;
            r.stickWave  <= 1'b0;
            r.prdata     <= 32'h0000_0000;
            r.pready     <= 1'b0;
            r.pslverr    <= 1'b0;
            r.startValid <= 1'b0;
            r.waveError  <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata     = r.prdata;
    assign pready     = r.pready;
    assign pslverr    = r.pslverr;
    assign startValid = r.startValid;
    assign waveError  = r.waveError;

    // Checks
    sequence dataRise;
        r.state == RX_DATA_LOW && rise && r.rxEnable;
    endsequence

    sequence checkOn;
        waveEn && r.rxEnable;
    endsequence

    AST_APB_ANSWER: assert property (@(posedge clk) disable iff (rst)
        psel && !penable |=> pready)
        else $error("pready missing after setup");

    AST_START_WIN_WRITE: assert property (@(posedge clk) disable iff (rst)
        psel && penable && pready && pwrite && isAddr(paddr, START_WIN_OFFSET)
        |=> cycMax == START_CYCLE_MAX_BASE + {5'h00, $past(pwdata[14:12])})
        else $error("start cycle max window wrong");

    AST_RISE_WIN: assert property (@(posedge clk) disable iff (rst)
        r.state == RX_START_LOW && rise && !inWin(cnt, riseMin, riseMax) && r.rxEnable
        |=> r.state == RX_IDLE ##1 !startValid)
        else $error("start rise outside window accepted");

    AST_START_VALID: assert property (@(posedge clk) disable iff (rst)
        startValid |-> $past(r.state) == RX_START_HIGH && $past(fall)
        && inWin($past(cnt), $past(cycMin), $past(cycMax)))
        else $error("start bit flagged outside windows");

    AST_WAVE_OFF: assert property (@(posedge clk) disable iff (rst)
        waveError |-> $past(waveEn))
        else $error("waveform error while check disabled");

    AST_GAP_ERROR: assert property (@(posedge clk) disable iff (rst)
        dataRise ##0 checkOn ##0 (cnt > oneMax && cnt < zeroMin) |=> waveError)
        else $error("gap rise not flagged");

    AST_ONE_OK: assert property (@(posedge clk) disable iff (rst)
        dataRise ##0 inWin(cnt, oneMin, oneMax) |=> !waveError)
        else $error("proper one flagged");

    AST_ZERO_OK: assert property (@(posedge clk) disable iff (rst)
        dataRise ##0 inWin(cnt, zeroMin, zeroMax) |=> !waveError)
        else $error("proper zero flagged");

    AST_ZERO_TIMEOUT: assert property (@(posedge clk) disable iff (rst)
        checkOn ##0 r.state == RX_DATA_LOW && !rise && cnt > zeroMax
        |=> waveError && r.state == RX_IDLE)
        else $error("missing rise not flagged");

    AST_RESTART: assert property (@(posedge clk) disable iff (rst)
        r.state == RX_DATA_HIGH && fall && r.rxEnable |=> bitCount == '0)
        else $error("bit timer not restarted");

endmodule

`default_nettype wire

// file: testbench/swrtc_line_model.sv
`default_nettype none

// Far-side talker: fast fs tick and received line level
module swrtc_line_model (
    input  wire logic clk,
    input  wire logic rst,
    output logic      sampleTick,
    output logic      lineIn
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase;

    initial begin
        lineIn = 1'b1;
    end

    // One tick every four clocks keeps frames short
    always @(posedge clk) begin
        phase      <= rst ? 2'h0 : phase + 2'h1;
        sampleTick <= !rst && (phase == 2'h3);
    end

    // Line moves one clock after a tick, so counts are exact
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge clk iff sampleTick === 1'b1);
        @(posedge clk);
    endtask

    // One bit: fall, low for lowT ticks, rise, high for highT ticks
    task automatic send_bit(input int lowT, input int highT);
        lineIn <= 1'b0;
        wait_ticks(lowT);
        lineIn <= 1'b1;
        wait_ticks(highT);
    endtask
endmodule

`default_nettype wire

// file: testbench/swrtc_top_tb.sv
`default_nettype none

module swrtc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swrtc_pkg::*;

    typedef struct {
        logic [15:0] sw;
        logic [23:0] dw;
        int          lowT;
        int          highT;
        int          dataT;
        int          expStart;
        int          expWave;
    } swrtc_row_type;

    // Window settings, start low/high ticks, data rise tick, expected pulses
    swrtc_row_type rows [31] = '{
        '{16'h0000, 24'h000001, 115, 26, 20, 1, 0},
        '{16'h0000, 24'h000001, 114, 27, 20, 0, 0},
        '{16'h0000, 24'h000001, 128, 26, 20, 1, 0},
        '{16'h0000, 24'h000001, 129, 25, 20, 0, 0},
        '{16'h0000, 24'h000001, 120, 20, 20, 0, 0},
        '{16'h0000, 24'h000001, 120, 35, 20, 0, 0},
        '{16'h7777, 24'h000001, 108, 53, 20, 1, 0},
        '{16'h7777, 24'h000001, 135, 26, 20, 1, 0},
        '{16'h7777, 24'h000001, 107, 30, 20, 0, 0},
        '{16'h7777, 24'h000001, 120, 13, 20, 0, 0},
        '{16'h7777, 24'h000001, 120, 42, 20, 0, 0},
        '{16'h0000, 24'h000001, 120, 25, 12, 1, 1},
        '{16'h0000, 24'h000001, 120, 25, 13, 1, 0},
        '{16'h0000, 24'h000001, 120, 25, 26, 1, 0},
        '{16'h0000, 24'h000001, 120, 25, 27, 1, 1},
        '{16'h0000, 24'h000001, 120, 25, 42, 1, 1},
        '{16'h0000, 24'h000001, 120, 25, 43, 1, 0},
        '{16'h0000, 24'h000001, 120, 25, 56, 1, 0},
        '{16'h0000, 24'h000001, 120, 25, 57, 1, 1},
        '{16'h0000, 24'h000001, 120, 25, 80, 1, 1},
        '{16'h0000, 24'h777701, 120, 25, 5, 1, 1},
        '{16'h0000, 24'h777701, 120, 25, 6, 1, 0},
        '{16'h0000, 24'h777701, 120, 25, 33, 1, 0},
        '{16'h0000, 24'h777701, 120, 25, 34, 1, 1},
        '{16'h0000, 24'h777701, 120, 25, 35, 1, 1},
        '{16'h0000, 24'h777701, 120, 25, 36, 1, 0},
        '{16'h0000, 24'h777701, 120, 25, 63, 1, 0},
        '{16'h0000, 24'h777701, 120, 25, 64, 1, 1},
        '{16'h0000, 24'h777701, 120, 25, 90, 1, 1},
        '{16'h0000, 24'h000000, 120, 25, 5, 1, 0},
        '{16'h0000, 24'h000000, 120, 25, 80, 1, 0}
    };

    logic        clk, rst, psel, penable, pwrite, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        pready, pslverr, sampleTick, lineIn, startValid, waveError;
    int          errTotal = 0, checksDone = 0, cycleCount = 0;
    int          startSeen = 0, waveSeen = 0, s0, w0;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    swrtc_top dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleTick(sampleTick), .lineIn(lineIn),
        .startValid(startValid), .waveError(waveError)
    );

    swrtc_line_model line_u (
        .clk(clk), .rst(rst), .sampleTick(sampleTick), .lineIn(lineIn)
    );

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (startValid === 1'b1) startSeen <= startSeen + 1;
        if (waveError === 1'b1) waveSeen <= waveSeen + 1;
        if (cycleCount == 60000) begin
            errTotal++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        checksDone++;
        if (got !== expv) begin
            $display("ERROR %s expected %h seen %h", what, expv, got);
            errTotal++;
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] expv);
        apb(1'b0, a, 32'h0);
        chk(what, expv, rdata);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_chk("start win reset", START_WIN_OFFSET, START_WIN_RESET);
        rd_chk("data win reset", DATA_WIN_OFFSET, DATA_WIN_RESET);
        foreach (rows[i]) begin
            apb(1'b1, RX_CTRL_OFFSET, 32'h0);
            rd_chk("rx ctrl off", RX_CTRL_OFFSET, 32'h0);
            apb(1'b1, START_WIN_OFFSET, {16'h0, rows[i].sw});
            apb(1'b1, DATA_WIN_OFFSET, {8'h0, rows[i].dw});
            apb(1'b1, RX_CTRL_OFFSET, 32'h1);
            s0 = startSeen;
            w0 = waveSeen;
            line_u.send_bit(rows[i].lowT, rows[i].highT);
            line_u.send_bit(rows[i].dataT, 20);
            line_u.send_bit(20, 20);
            repeat (4) @(posedge clk);
            chk($sformatf("row %0d start", i), 32'(rows[i].expStart), 32'(startSeen - s0));
            chk($sformatf("row %0d wave", i), 32'(rows[i].expWave), 32'(waveSeen - w0));
        end
        apb(1'b0, RX_STATUS_OFFSET, 32'h0);
        chk("status sticky", 32'h3, rdata & 32'h3);
        apb(1'b1, RX_STATUS_OFFSET, 32'h3);
        apb(1'b0, RX_STATUS_OFFSET, 32'h0);
        chk("status cleared", 32'h0, rdata & 32'h3);
        // Receiver off ignores a good start bit
        apb(1'b1, RX_CTRL_OFFSET, 32'h0);
        s0 = startSeen;
        line_u.send_bit(120, 25);
        line_u.send_bit(20, 20);
        chk("disabled start", 32'h0, 32'(startSeen - s0));
        rd_chk("rx ctrl stopped", RX_CTRL_OFFSET, 32'h0);
        apb(1'b1, START_WIN_OFFSET, 32'hFFFFFFFF);
        rd_chk("start win mask", START_WIN_OFFSET, START_WIN_MASK);
        apb(1'b1, DATA_WIN_OFFSET, 32'hFFFFFFFF);
        rd_chk("data win mask", DATA_WIN_OFFSET, DATA_WIN_MASK);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdata);
        // Second reset in mid-run
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk("start win rereset", START_WIN_OFFSET, START_WIN_RESET);
        rd_chk("data win rereset", DATA_WIN_OFFSET, DATA_WIN_RESET);
        tally_and_finish();
    end
endmodule

`default_nettype wire
